/* File: design/btwd_counter.sv */
`timescale 1ns/1ns
module btwd_counter
   import btwd_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic clear,
   input wire logic tick,
   // Outputs
   output logic [7:0] value,
   output logic overflow
);

   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;

   assign cnt_nxt = clear ? BTWD_CNT_RESET :
                    tick ? 8'(cnt_r + 8'h01) : cnt_r;
   assign overflow = !clear && tick && (cnt_r == 8'hff);
   assign value = cnt_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_r <= BTWD_CNT_RESET;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

endmodule

/* File: design/btwd_pkg.sv */
package btwd_pkg;

   // ***************************************************
   // Register map (byte addresses, one word each)
   // ***************************************************
   localparam logic [7:0] BTWD_CTRL_INDEX = 8'hdc;
   localparam logic [7:0] BTWD_CNT_INDEX = 8'hdd;
   localparam logic [11:0] BTWD_CTRL_ADDR = 12'h370;
   localparam logic [11:0] BTWD_CNT_ADDR = 12'h374;
   localparam logic [7:0] BTWD_CTRL_RESET = 8'h00;
   localparam logic [7:0] BTWD_CNT_RESET = 8'h00;

   // ***************************************************
   // Control fields
   // ***************************************************
   localparam int BTWD_KEY_LSB = 4;
   localparam logic [3:0] BTWD_KEY_DISABLE = 4'ha;
   localparam int BTWD_SEL_LSB = 2;
   localparam int BTWD_CNT_CLR_BIT = 1;
   localparam int BTWD_DIV_CLR_BIT = 0;

   // ***************************************************
   // Divider taps
   // ***************************************************
   localparam int BTWD_DIV_W = 12;
   localparam int BTWD_DIV_4096 = 4096;
   localparam int BTWD_DIV_1024 = 1024;
   localparam int BTWD_DIV_128 = 128;
   localparam logic [1:0] BTWD_SEL_4096 = 2'h0;
   localparam logic [1:0] BTWD_SEL_1024 = 2'h1;
   localparam logic [1:0] BTWD_SEL_128 = 2'h2;

   localparam logic [1:0] BTWD_RESP_OKAY = 2'h0;
   localparam logic [1:0] BTWD_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [3:0] key;
      logic [1:0] sel;
      logic cnt_clr;
      logic div_clr;
   } btwd_ctrl_s;

endpackage

/* File: design/btwd_prescaler.sv */
`timescale 1ns/1ns
module btwd_prescaler
   import btwd_pkg::*;
#(
   parameter int W = BTWD_DIV_W
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control
   input wire logic clear,
   input wire logic [1:0] sel,
   // Outputs
   output logic tick,
   output logic [W-1:0] count
);

   logic [W-1:0] div_r;
   logic [W-1:0] div_nxt;
   logic [W-1:0] mask;

   // Tick on wrap of the selected low bits; 11 gives no tick at all
   assign mask = (sel == BTWD_SEL_4096) ? W'(BTWD_DIV_4096 - 1) :
                 (sel == BTWD_SEL_1024) ? W'(BTWD_DIV_1024 - 1) :
                 (sel == BTWD_SEL_128) ? W'(BTWD_DIV_128 - 1) : '0;
   assign div_nxt = clear ? '0 : W'(div_r + 1'b1);
   assign tick = !clear && (sel != 2'h3) && ((div_r & mask) == mask);
   assign count = div_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_r <= '0;
      end else begin
         div_r <= div_nxt;
      end
   end

endmodule

/* File: design/btwd_top.sv */
// Chosen here: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// How it works
// - Watchdog is off only while the control key nibble equals 1010.
// - Bits 3:2 pick divide by 4096, 1024 or 128; 11 is invalid.
// - An 8-bit basic timer counter exists and can be cleared.
// - Writing 1 to bit 1 zeroes the counter; writing 0 does nothing.
// - Writing 1 to bit 0 clears the single prescale divider.
// - Each clear bit returns to 0 by itself once its clear is done.
// - Software reads the count from a read-only register resetting to zero.
module btwd_top
   import btwd_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timer outputs
   output logic timer0_div_clear,
   output logic watchdog_enabled,
   output logic system_reset_req
);

   // ***************************************************
   // Write channel
   // ***************************************************
   logic aw_held_r;
   logic [11:0] aw_addr_r;
   logic w_held_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic wr_go;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_ctrl;
   logic wr_ctrl_lane0;

   // Address and data may come in either order; each is latched alone
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
   assign wr_data = w_held_r ? w_data_r : s_axi_wdata;
   assign wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
   assign wr_go = !bvalid_r && (aw_held_r || s_axi_awvalid) &&
                  (w_held_r || s_axi_wvalid);
   assign wr_ctrl = wr_go && (wr_addr[11:2] == BTWD_CTRL_ADDR[11:2]);
   assign wr_ctrl_lane0 = wr_ctrl && wr_strb[0];
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= '0;
      end else if (wr_go) begin
         aw_held_r <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
      end else if (wr_go) begin
         w_held_r <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end
   end

   // Counter register is read-only, so a write to it is an error too
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_r <= 1'b0;
         bresp_r <= BTWD_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= wr_ctrl ? BTWD_RESP_OKAY : BTWD_RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_r <= 1'b0;
      end
   end

   // ***************************************************
   // Control register
   // ***************************************************
   btwd_ctrl_s ctrl_r;
   btwd_ctrl_s ctrl_nxt;
   btwd_ctrl_s wr_ctrl_val;

   assign wr_ctrl_val = btwd_ctrl_s'(wr_data[7:0]);

   // Clear bits act for one cycle, then drop back to zero unaided
   always_comb begin
      ctrl_nxt = ctrl_r;
      ctrl_nxt.cnt_clr = 1'b0;
      ctrl_nxt.div_clr = 1'b0;
      if (wr_ctrl_lane0) begin
         ctrl_nxt.key = wr_ctrl_val.key;
         ctrl_nxt.sel = wr_ctrl_val.sel;
         ctrl_nxt.cnt_clr = wr_ctrl_val.cnt_clr;
         ctrl_nxt.div_clr = wr_ctrl_val.div_clr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r <= btwd_ctrl_s'(BTWD_CTRL_RESET);
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // ***************************************************
   // Timer datapath
   // ***************************************************
   logic bt_tick;
   logic [7:0] cnt_value;
   logic cnt_overflow;
   logic wd_en;
   logic sys_rst_r;

   btwd_prescaler #(
      .W(BTWD_DIV_W)
   ) u_prescaler (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(ctrl_r.div_clr),
      .sel(ctrl_r.sel),
      .tick(bt_tick),
      .count()
   );

   btwd_counter u_counter (
      .aclk(aclk),
      .aresetn(aresetn),
      .clear(ctrl_r.cnt_clr),
      .tick(bt_tick),
      .value(cnt_value),
      .overflow(cnt_overflow)
   );

   assign wd_en = (ctrl_r.key != BTWD_KEY_DISABLE);
   assign watchdog_enabled = wd_en;
   assign timer0_div_clear = ctrl_r.div_clr;

   // Registered so the reset request is a clean one-cycle pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sys_rst_r <= 1'b0;
      end else begin
         sys_rst_r <= wd_en && cnt_overflow;
      end
   end
   assign system_reset_req = sys_rst_r;

   // ***************************************************
   // Read channel
   // ***************************************************
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic rd_go;
   logic rd_ctrl;
   logic rd_cnt;

   assign s_axi_arready = !rvalid_r;
   assign rd_go = s_axi_arvalid && !rvalid_r;
   assign rd_ctrl = (s_axi_araddr[11:2] == BTWD_CTRL_ADDR[11:2]);
   assign rd_cnt = (s_axi_araddr[11:2] == BTWD_CNT_ADDR[11:2]);
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= BTWD_RESP_OKAY;
      end else if (rd_go) begin
         rvalid_r <= 1'b1;
         rdata_r <= rd_ctrl ? {24'h000000, ctrl_r} :
                    rd_cnt ? {24'h000000, cnt_value} : '0;
         rresp_r <= (rd_ctrl || rd_cnt) ? BTWD_RESP_OKAY : BTWD_RESP_SLVERR;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

endmodule

/* File: test/btwd_props.sv */
`timescale 1ns/1ns
module btwd_props
   import btwd_pkg::*;
(
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Timer
   input wire logic timer0_div_clear,
   input wire logic watchdog_enabled,
   input wire logic system_reset_req
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Only writes with address and data in the same cycle are judged
   wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire ctl_go = wr_go && s_axi_wstrb[0] &&
      s_axi_awaddr[11:2] == BTWD_CTRL_ADDR[11:2];
   a_key_gate: assert property (ctl_go |=> watchdog_enabled ==
      ($past(s_axi_wdata[7:4]) != BTWD_KEY_DISABLE)) else $error("key bad");
   a_div_pulse: assert property (ctl_go && s_axi_wdata[0] |->
      ##[1:2] timer0_div_clear) else $error("no divider clear");
   a_div_single: assert property (timer0_div_clear |=>
      !timer0_div_clear) else $error("divider clear held");
   a_ctl_okay: assert property (ctl_go |=> s_axi_bvalid &&
      s_axi_bresp == BTWD_RESP_OKAY) else $error("control write refused");
   a_bad_resp: assert property (wr_go &&
      s_axi_awaddr[11:2] != BTWD_CTRL_ADDR[11:2]
      |=> s_axi_bresp == BTWD_RESP_SLVERR) else $error("bad write accepted");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write resp dropped");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read not answered");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_rst_gate: assert property (system_reset_req |->
      $past(watchdog_enabled)) else $error("reset with watchdog off");
   a_rst_single: assert property (system_reset_req |=>
      !system_reset_req) else $error("reset request held");
endmodule
bind btwd_top btwd_props btwd_props_inst (.*);

/* File: test/testbench.sv */
`timescale 1ns/1ns
module testbench
   import btwd_pkg::*;
;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire logic s_axi_rvalid, timer0_div_clear, watchdog_enabled;
   wire logic system_reset_req;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   int mismatches = 0, num_checks = 0, cyc = 0;
   btwd_top btwd_top_inst (.*);
   always #5 aclk = ~aclk;
   // Longest path is one 32768-cycle overflow wait plus one full 33500-cycle wait
   always @(posedge aclk) begin
      cyc++;
      if (cyc > 95000) begin
         mismatches++;
         end_sim();
      end
   end
   // ****************
   // Shared tasks
   // ****************
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e) begin
         mismatches++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      chk("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
      s_axi_bready <= 0;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      chk("rdata", s_axi_rdata, e);
      chk("rresp", {30'h0, s_axi_rresp}, {30'h0, r});
      s_axi_rready <= 0;
   endtask
   task wait_req(input int lim, output int c);
      c = 0;
      while (system_reset_req !== 1'b1 && c < lim) begin
         @(posedge aclk);
         c++;
      end
   endtask
   // ****************
   // Scenarios
   // ****************
   task t_reset_vals;
      rd(BTWD_CTRL_ADDR, 32'h0, BTWD_RESP_OKAY);
      rd(BTWD_CNT_ADDR, 32'h0, BTWD_RESP_OKAY);
      chk("wd_en", {31'h0, watchdog_enabled}, 32'h1);
   endtask
   task t_keys;
      // Slowest rate keeps any overflow far off while the keys change
      for (int k = 0; k < 16; k++) begin
         wr(BTWD_CTRL_ADDR, {24'h0, 4'(k), 4'h0}, BTWD_RESP_OKAY);
         chk("wd_en", {31'h0, watchdog_enabled}, 32'(k != 10));
         rd(BTWD_CTRL_ADDR, {24'h0, 4'(k), 4'h0}, BTWD_RESP_OKAY);
      end
   endtask
   task t_rates;
      int d [4] = '{BTWD_DIV_4096, BTWD_DIV_1024, BTWD_DIV_128, BTWD_DIV_128};
      logic [1:0] s [4] = '{BTWD_SEL_4096, BTWD_SEL_1024, BTWD_SEL_128,
         BTWD_SEL_128};
      // Last pass repeats the fastest rate: the clear must restart the count
      for (int i = 0; i < 4; i++) begin
         wr(BTWD_CTRL_ADDR, {24'h0, 4'ha, s[i], 2'h3}, BTWD_RESP_OKAY);
         repeat (d[i] * 3 + d[i] / 2) @(posedge aclk);
         rd(BTWD_CNT_ADDR, 32'h3, BTWD_RESP_OKAY);
         rd(BTWD_CTRL_ADDR, {24'h0, 4'ha, s[i], 2'h0}, BTWD_RESP_OKAY);
      end
   endtask
   task t_count_clear;
      wr(BTWD_CTRL_ADDR, 32'hab, BTWD_RESP_OKAY);
      repeat (448) @(posedge aclk);
      rd(BTWD_CNT_ADDR, 32'h3, BTWD_RESP_OKAY);
      wr(BTWD_CTRL_ADDR, 32'ha8, BTWD_RESP_OKAY);
      rd(BTWD_CNT_ADDR, 32'h3, BTWD_RESP_OKAY);
      wr(BTWD_CTRL_ADDR, 32'haa, BTWD_RESP_OKAY);
      rd(BTWD_CNT_ADDR, 32'h0, BTWD_RESP_OKAY);
      rd(BTWD_CTRL_ADDR, 32'ha8, BTWD_RESP_OKAY);
   endtask
   task t_unmapped;
      wr(12'h100, 32'h5, BTWD_RESP_SLVERR);
      rd(12'h100, 32'h0, BTWD_RESP_SLVERR);
      wr(BTWD_CNT_ADDR, 32'hff, BTWD_RESP_SLVERR);
      rd(BTWD_CNT_ADDR, 32'h0, BTWD_RESP_OKAY);
      // Control write without byte lane 0 leaves the register alone
      s_axi_wstrb <= 4'he;
      wr(BTWD_CTRL_ADDR, 32'h5, BTWD_RESP_OKAY);
      s_axi_wstrb <= 4'hf;
      rd(BTWD_CTRL_ADDR, 32'ha8, BTWD_RESP_OKAY);
   endtask
   task t_watchdog;
      int c;
      wr(BTWD_CTRL_ADDR, 32'h0b, BTWD_RESP_OKAY);
      wait_req(33500, c);
      chk("wd_time", 32'(c > 32760 && c < 32780), 32'h1);
      wr(BTWD_CTRL_ADDR, 32'hab, BTWD_RESP_OKAY);
      wait_req(33500, c);
      chk("wd_off", 32'(c), 32'd33500);
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      t_reset_vals();
      t_keys();
      t_rates();
      t_count_clear();
      t_unmapped();
      t_watchdog();
      end_sim();
   end
endmodule
